//--- hdl/pots_top.sv
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module pots_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic u_phase_pwm_signal,
  input wire logic v_phase_pwm_signal,
  input wire logic w_phase_pwm_signal,
  input wire logic [15:0] carrier_count,
  input wire pots_pkg::pots_trg_mode_t trigger_mode,
  input wire logic trigger_select_out_mode,
  output logic u_upper_out,
  output logic u_lower_out,
  output logic v_upper_out,
  output logic v_lower_out,
  output logic w_upper_out,
  output logic w_lower_out,
  output logic trigger_a_pulse,
  output logic trigger_b_pulse,
  output logic [2:0] trigger_number,
  output logic trigger_number_valid,
  output logic [15:0] trigger_correction_out
);
  import pots_pkg::*;

  logic [8:0] outctrl_reg;
  logic [15:0] trigger_correction;
  logic [15:0] trigger_compare_a;
  logic [15:0] trigger_compare_b;
  logic [2:0] trigger_number_select;
  logic cmp_active;
  logic sel_active;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_next;
  logic [2:0] pwm_sel;
  logic [5:0] oc_field;
  logic [2:0] phase_pwm;
  logic [2:0] upper_vec;
  logic [2:0] lower_vec;
  logic trig_sel_raw;

  // address decode used for both read and write checks
  function automatic logic pots_mapped(input logic [7:0] a);
    pots_mapped = (a == POTS_OFS_OUTCTRL) || (a == POTS_OFS_CORR) || (a == POTS_OFS_CMPA) ||
                  (a == POTS_OFS_CMPB) || (a == POTS_OFS_TRGSEL) || (a == POTS_OFS_STATUS);
  endfunction

  // zero-wait apb: access phase completes on the first penable cycle
  assign addr_ok = pots_mapped(paddr);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;

  // pready is registered so it comes from a flop; it rises in the access cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // phase output control register, only bits 8..0 kept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outctrl_reg <= POTS_OUTCTRL_RST;
    end else if (wr_en && paddr == POTS_OFS_OUTCTRL) begin
      outctrl_reg <= pwdata[POTS_OUTCTRL_W-1:0];
    end
  end

  // correction value, 16 bits, upper half of word dropped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_correction <= POTS_VAL16_RST;
    end else if (wr_en && paddr == POTS_OFS_CORR) begin
      trigger_correction <= pwdata[15:0];
    end
  end

  // compare points; range checking is software's job, hardware stores as written
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_compare_a <= POTS_VAL16_RST;
      trigger_compare_b <= POTS_VAL16_RST;
    end else begin
      if (wr_en && paddr == POTS_OFS_CMPA) begin
        trigger_compare_a <= pwdata[15:0];
      end
      if (wr_en && paddr == POTS_OFS_CMPB) begin
        trigger_compare_b <= pwdata[15:0];
      end
    end
  end

  // trigger number select, three bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_number_select <= POTS_TRGSEL_RST;
    end else if (wr_en && paddr == POTS_OFS_TRGSEL) begin
      trigger_number_select <= pwdata[POTS_TRGSEL_W-1:0];
    end
  end

  // read mux; unmapped and unused bits read zero
  always_comb begin
    rd_next = 32'h00000000;
    case (paddr)
      POTS_OFS_OUTCTRL: rd_next = {23'h000000, outctrl_reg};
      POTS_OFS_CORR: rd_next = {16'h0000, trigger_correction};
      POTS_OFS_CMPA: rd_next = {16'h0000, trigger_compare_a};
      POTS_OFS_CMPB: rd_next = {16'h0000, trigger_compare_b};
      POTS_OFS_TRGSEL: rd_next = {29'h00000000, trigger_number_select};
      POTS_OFS_STATUS: rd_next = {30'h00000000, sel_active, cmp_active};
      default: rd_next = 32'h00000000;
    endcase
  end

  // read data captured in setup so it is stable through the access phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= rd_next;
    end
  end

  // the a and b compares only act in match modes and never in trigger-select output mode
  always_comb begin
    case (trigger_mode)
      POTS_TM_DOWN: cmp_active = !trigger_select_out_mode;
      POTS_TM_UP: cmp_active = !trigger_select_out_mode;
      POTS_TM_UPDOWN: cmp_active = !trigger_select_out_mode;
      default: cmp_active = 1'b0;
    endcase
  end
  assign sel_active = trigger_select_out_mode && (trigger_number_select <= POTS_TRGSEL_MAX);

  // gather per-phase settings into vectors for the generate loop
  assign pwm_sel = {outctrl_reg[POTS_W_PWM_BIT], outctrl_reg[POTS_V_PWM_BIT], outctrl_reg[POTS_U_PWM_BIT]};
  assign oc_field = {outctrl_reg[POTS_W_OC_LSB+1:POTS_W_OC_LSB], outctrl_reg[POTS_V_OC_LSB+1:POTS_V_OC_LSB],
                     outctrl_reg[POTS_U_OC_LSB+1:POTS_U_OC_LSB]};
  assign phase_pwm = {w_phase_pwm_signal, v_phase_pwm_signal, u_phase_pwm_signal};

  // same output stage for u, v and w
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_phase
      pots_phase_out u_stage (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pwm_sel(pwm_sel[gi]),
        .out_ctrl(oc_field[2*gi+1:2*gi]),
        .phase_pwm(phase_pwm[gi]),
        .upper_out(upper_vec[gi]),
        .lower_out(lower_vec[gi])
      );
    end
  endgenerate
  assign u_upper_out = upper_vec[0];
  assign u_lower_out = lower_vec[0];
  assign v_upper_out = upper_vec[1];
  assign v_lower_out = lower_vec[1];
  assign w_upper_out = upper_vec[2];
  assign w_lower_out = lower_vec[2];

  // first plain trigger; cmp_active already excludes select mode, so the pin comes straight from a flop
  pots_trig_cmp u_cmp_a (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .active(cmp_active),
    .carrier_count(carrier_count),
    .cmp_value(trigger_compare_a),
    .correction(trigger_correction),
    .trig_pulse(trigger_a_pulse)
  );
  // second trigger, same gating as the first
  pots_trig_cmp u_cmp_b (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .active(cmp_active),
    .carrier_count(carrier_count),
    .cmp_value(trigger_compare_b),
    .correction(trigger_correction),
    .trig_pulse(trigger_b_pulse)
  );
  // in select mode the first compare point times the trigger number instead;
  // a comparator of its own avoids gating a flop output with the mode input
  pots_trig_cmp u_cmp_sel (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .active(sel_active),
    .carrier_count(carrier_count),
    .cmp_value(trigger_compare_a),
    .correction(trigger_correction),
    .trig_pulse(trig_sel_raw)
  );

  // selected trigger number out, registered; prohibited values still reach trigger_number, without valid unless one is written at the edge trig_sel_raw rises
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_number <= 3'h0;
      trigger_number_valid <= 1'b0;
      trigger_correction_out <= POTS_VAL16_RST;
    end else begin
      trigger_number <= trigger_number_select;
      trigger_number_valid <= trig_sel_raw;
      trigger_correction_out <= trigger_correction;
    end
  end
endmodule

//--- hdl/pots_pkg.sv
package pots_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] POTS_OFS_OUTCTRL = 8'h00;
  localparam logic [7:0] POTS_OFS_CORR = 8'h04;
  localparam logic [7:0] POTS_OFS_CMPA = 8'h08;
  localparam logic [7:0] POTS_OFS_CMPB = 8'h0C;
  localparam logic [7:0] POTS_OFS_TRGSEL = 8'h10;
  localparam logic [7:0] POTS_OFS_STATUS = 8'h14;
  // output control field positions
  localparam int POTS_U_OC_LSB = 0;
  localparam int POTS_V_OC_LSB = 2;
  localparam int POTS_W_OC_LSB = 4;
  localparam int POTS_U_PWM_BIT = 6;
  localparam int POTS_V_PWM_BIT = 7;
  localparam int POTS_W_PWM_BIT = 8;
  localparam int POTS_OUTCTRL_W = 9;
  localparam int POTS_TRGSEL_W = 3;
  localparam logic [2:0] POTS_TRGSEL_MAX = 3'h5;
  // reset values
  localparam logic [8:0] POTS_OUTCTRL_RST = 9'h000;
  localparam logic [15:0] POTS_VAL16_RST = 16'h0000;
  localparam logic [2:0] POTS_TRGSEL_RST = 3'h0;
  // driver trigger modes
  typedef enum logic [2:0] {
    POTS_TM_OFF = 3'b000,
    POTS_TM_DOWN = 3'b001,
    POTS_TM_UP = 3'b010,
    POTS_TM_UPDOWN = 3'b011,
    POTS_TM_PEAK = 3'b100,
    POTS_TM_BOTTOM = 3'b101,
    POTS_TM_OTHER6 = 3'b110,
    POTS_TM_OTHER7 = 3'b111
  } pots_trg_mode_t;
endpackage

//--- hdl/pots_phase_out.sv
`timescale 1ns/1ps
// one phase pair: on/off or complementary pwm, registered outputs
module pots_phase_out (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pwm_sel,
  input wire logic [1:0] out_ctrl,
  input wire logic phase_pwm,
  output logic upper_out,
  output logic lower_out
);
  // pwm select drives both outputs from the pwm, complementary; upper bit of field sets upper polarity
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_out <= 1'b0;
      lower_out <= 1'b0;
    end else if (pwm_sel) begin
      upper_out <= out_ctrl[1] ? phase_pwm : ~phase_pwm;
      lower_out <= out_ctrl[1] ? ~phase_pwm : phase_pwm;
    end else begin
      upper_out <= out_ctrl[1];
      lower_out <= out_ctrl[0];
    end
  end
endmodule

//--- hdl/pots_trig_cmp.sv
`timescale 1ns/1ps
// one compare point: pulses when carrier count hits the corrected compare value
module pots_trig_cmp (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic [15:0] carrier_count,
  input wire logic [15:0] cmp_value,
  input wire logic [15:0] correction,
  output logic trig_pulse
);
  logic [15:0] target;
  logic [15:0] prev_count_reg;
  // correction shifts the match point; sum wraps on purpose
  assign target = 16'(cmp_value + correction);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_count_reg <= 16'h0000;
      trig_pulse <= 1'b0;
    end else begin
      prev_count_reg <= carrier_count;
      // fire once per arrival at the target, not every cycle the count rests there
      trig_pulse <= active && (carrier_count == target) && (prev_count_reg != target);
    end
  end
endmodule

//--- verification/pots_monitor.sv
`timescale 1ns/1ps
// sees only the top ports; register fields are mirrored from completed apb writes
module pots_monitor
  import pots_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic u_phase_pwm_signal,
  input wire logic v_phase_pwm_signal,
  input wire logic w_phase_pwm_signal,
  input wire pots_pkg::pots_trg_mode_t trigger_mode,
  input wire logic trigger_select_out_mode,
  input wire logic u_upper_out,
  input wire logic u_lower_out,
  input wire logic v_upper_out,
  input wire logic v_lower_out,
  input wire logic w_upper_out,
  input wire logic w_lower_out,
  input wire logic trigger_a_pulse,
  input wire logic trigger_b_pulse,
  input wire logic [2:0] trigger_number,
  input wire logic trigger_number_valid,
  input wire logic [15:0] trigger_correction_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [8:0] oc_q;
  logic [15:0] cr_q;
  wire wr = psel && penable && pready && pwrite;
  wire act = trigger_mode inside {POTS_TM_DOWN, POTS_TM_UP, POTS_TM_UPDOWN} && !trigger_select_out_mode;
  // {upper, lower} for one phase; odd codes under pwm follow the upper field bit
  function automatic logic [1:0] pair(input logic s, input logic [1:0] oc, input logic p);
    return s ? (oc[1] ? {p, ~p} : {~p, p}) : oc;
  endfunction
  wire [1:0] eu = pair(oc_q[6], oc_q[1:0], u_phase_pwm_signal);
  wire [1:0] ev = pair(oc_q[7], oc_q[3:2], v_phase_pwm_signal);
  wire [1:0] ew = pair(oc_q[8], oc_q[5:4], w_phase_pwm_signal);
  // mirror updates at the same edge as the slave register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_q <= 9'h000;
      cr_q <= 16'h0000;
    end else if (wr && paddr == POTS_OFS_OUTCTRL) begin
      oc_q <= pwdata[8:0];
    end else if (wr && paddr == POTS_OFS_CORR) begin
      cr_q <= pwdata[15:0];
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready;
  endsequence
  ready_next_a: assert property (setup_s |=> answer_s) else $error("no ready after setup");
  unmapped_err_a: assert property (setup_s ##0 paddr > POTS_OFS_STATUS |=> answer_s ##0 pslverr)
    else $error("unmapped access not refused");
  read_zero_a: assert property (pready && !pwrite |-> (paddr == POTS_OFS_OUTCTRL ? prdata[31:9] == 23'h0
    : prdata[31:16] == 16'h0000)) else $error("unused read bits not zero");
  phase_u_a: assert property (1 |=> {u_upper_out, u_lower_out} == $past(eu))
    else $error("u pair wrong");
  phase_v_a: assert property (1 |=> {v_upper_out, v_lower_out} == $past(ev))
    else $error("v pair wrong");
  phase_w_a: assert property (1 |=> {w_upper_out, w_lower_out} == $past(ew))
    else $error("w pair wrong");
  corr_track_a: assert property ($stable(cr_q) |-> trigger_correction_out == cr_q) else $error("correction stale");
  trig_a_gate_a: assert property (trigger_a_pulse |-> $past(act))
    else $error("first trigger outside match mode");
  trig_b_gate_a: assert property (trigger_b_pulse |-> $past(act))
    else $error("second trigger outside match mode");
  trig_b_once_a: assert property (trigger_b_pulse |=> !trigger_b_pulse) else $error("second trigger too long");
  num_legal_a: assert property (trigger_number_valid |-> trigger_number <= POTS_TRGSEL_MAX)
    else $error("illegal trigger number");
  valid_sel_mode_a: assert property (trigger_number_valid |-> $past(trigger_select_out_mode, 2))
    else $error("trigger number outside select mode");
endmodule
bind pots_top pots_monitor i_pots_monitor (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .u_phase_pwm_signal, .v_phase_pwm_signal, .w_phase_pwm_signal, .trigger_mode,
  .trigger_select_out_mode, .u_upper_out, .u_lower_out, .v_upper_out, .v_lower_out, .w_upper_out, .w_lower_out,
  .trigger_a_pulse, .trigger_b_pulse, .trigger_number, .trigger_number_valid, .trigger_correction_out);

//--- verification/pots_drv_model.sv
`timescale 1ns/1ps
// motor driver side: carrier counter and three phase pwm levels of different rates
module pots_drv_model #(
  parameter int PERIOD = 32
) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic [15:0] carrier_count,
  output logic [2:0] pwm
);
  // wraps below the period so legal compare points are 1 to PERIOD-1
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) carrier_count <= 16'h0000;
    else carrier_count <= (carrier_count == 16'(PERIOD - 1)) ? 16'h0000 : carrier_count + 16'h0001;
  end
  // registered so the levels move only just after an edge
  always_ff @(posedge core_clk) pwm <= {carrier_count[4], carrier_count[3], carrier_count[2]};
endmodule

//--- verification/pots_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module pots_top_tb;
  import pots_pkg::*;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sel_out = 0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  pots_trg_mode_t mode = POTS_TM_OFF;
  logic [15:0] cnt, ca, cb;
  logic [2:0] pwm, pd, tn, nn;
  logic [5:0] po;
  logic ta, tb, tv;
  int n_errors = 0, comparisons = 0, na, nb, nv;
  pots_drv_model i_pots_drv_model (.core_clk(core_clk), .rst_n(rst_n), .carrier_count(cnt), .pwm(pwm));
  pots_top i_pots_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .u_phase_pwm_signal(pwm[0]), .v_phase_pwm_signal(pwm[1]), .w_phase_pwm_signal(pwm[2]),
    .carrier_count(cnt), .trigger_mode(mode), .trigger_select_out_mode(sel_out), .u_upper_out(po[1]),
    .u_lower_out(po[0]), .v_upper_out(po[3]), .v_lower_out(po[2]), .w_upper_out(po[5]), .w_lower_out(po[4]),
    .trigger_a_pulse(ta), .trigger_b_pulse(tb), .trigger_number(tn), .trigger_number_valid(tv),
    .trigger_correction_out());
  initial forever #5 core_clk = ~core_clk;
  // pwm as the design saw it at the last edge
  always @(posedge core_clk) pd <= pwm;
  // one apb transfer, entered just after a rising edge; the answer is taken at the edge that
  // samples pready high, the request is released there, and one idle edge keeps calls apart
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  // counts trigger events over exactly one carrier period
  task watch;
    na = 0; nb = 0; nv = 0;
    repeat (32) begin
      @(negedge core_clk);
      if (ta === 1'b1) begin na++; ca = cnt; end
      if (tb === 1'b1) begin nb++; cb = cnt; end
      if (tv === 1'b1) begin nv++; nn = tn; end
    end
    @(posedge core_clk);
  endtask
  task t_reset;
    for (int i = 0; i < 6; i++) rdchk(8'(4 * i), 32'h0000_0000);
  endtask
  task t_regs;
    logic [31:0] e;
    for (int i = 0; i < 5; i++) begin
      // compare points get an in-period value, software may not load them outside it
      e = i == 0 ? 32'h0000_01FF : i == 1 ? 32'h0000_FFFF : i == 4 ? 32'h0000_0007 : 32'h0000_001F;
      apb(1'b1, 8'(4 * i), (i == 2 || i == 3) ? 32'hFFFF_001F : 32'hFFFF_FFFF);
      rdchk(8'(4 * i), e);
    end
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    rdchk(8'h18, 32'h0000_0000);
    `CHK(er, 1'b1)
  endtask
  task t_phase;
    logic s;
    logic [1:0] oc, e;
    for (int ph = 0; ph < 3; ph++) for (int c = 0; c < 6; c++) begin
      s = c > 3;
      oc = c == 5 ? 2'b11 : c == 4 ? 2'b00 : 2'(c);
      apb(1'b1, POTS_OFS_OUTCTRL, (32'(oc) << 2 * ph) | (32'(s) << (6 + ph)));
      @(negedge core_clk);
      e = s ? (oc[1] ? {pd[ph], ~pd[ph]} : {~pd[ph], pd[ph]}) : oc;
      `CHK({po[2 * ph + 1], po[2 * ph]}, e)
      @(posedge core_clk);
    end
  endtask
  task t_trig;
    apb(1'b1, POTS_OFS_CORR, 32'h0000_0002);
    apb(1'b1, POTS_OFS_CMPA, 32'h0000_0005);
    apb(1'b1, POTS_OFS_CMPB, 32'h0000_0009);
    apb(1'b1, POTS_OFS_TRGSEL, 32'h0000_0004);
    for (int m = 0; m < 8; m++) begin
      mode <= pots_trg_mode_t'(m);
      @(posedge core_clk);
      watch;
      `CHK(na, int'(m >= 1 && m <= 3))
      `CHK(nb, int'(m >= 1 && m <= 3))
      if (m == 2) begin
        `CHK(ca, 16'h0008)
        `CHK(cb, 16'h000C)
      end
    end
    sel_out <= 1'b1;
    mode <= POTS_TM_UP;
    // the number pulse lags the compare by a cycle, so skip one more edge before counting
    @(posedge core_clk);
    @(posedge core_clk);
    watch;
    `CHK(na + nb, 0)
    `CHK(nv, 1)
    `CHK(nn, 3'h4)
    apb(1'b1, POTS_OFS_TRGSEL, 32'h0000_0006);
    @(posedge core_clk);
    watch;
    `CHK(nv, 0)
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard: the whole sequence needs under two thousand cycles
  initial begin
    #100000;
    n_errors++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_regs;
    t_phase;
    t_trig;
    conclude;
  end
endmodule
